// file: shared/swbt_pkg.sv
// Constants, types and the CRC helper for the block transaction framer
// How it works
// - Transmit after wake returns status 0x11
// - Success returns output block, rereads repeat it
// - Unexecutable command answers code 0x0F
// - Communication error answers 0xFF, no execution
// - Status codes go out as four-byte blocks
// - Parse delay first, then error code reply
// - Clean parse runs execution, Transmit ignored meanwhile
// - Sleep flag resets engine and IO buffer
// - Sleep accepted wherever flags are accepted
// - Byte zero counts every byte of block
// - CRC-16 poly 0x8005, initial value zero
// - CRC low byte first, high byte last
// - Flags 0x66 command, 0x99 transmit, 0xCC sleep
// - Parse delay at most 100 microseconds
// - Bytes LSB first, fields in received order
package swbt_pkg;

  // ==========================================================
  // Flags, codes and block limits
  localparam logic [7:0] FLAG_COMMAND  = 8'h66;
  localparam logic [7:0] FLAG_TRANSMIT = 8'h99;
  localparam logic [7:0] FLAG_SLEEP    = 8'hCC;
  localparam logic [7:0] CODE_WAKE     = 8'h11;
  localparam logic [7:0] CODE_EXEC_ERR = 8'h0F;
  localparam logic [7:0] CODE_COMM_ERR = 8'hFF;
  localparam logic [7:0] BLOCK_MIN     = 8'h04;
  localparam logic [7:0] BLOCK_MAX     = 8'h27;
  localparam logic [7:0] BLOCK_EXTRA   = 8'h03;
  localparam logic [7:0] CODE_BLOCK    = 8'h04;
  localparam logic [15:0] CRC_POLY     = 16'h8005;
  localparam logic [15:0] CRC_INIT     = 16'h0000;

  // ==========================================================
  // Timing
  localparam int CLK_KHZ        = 20000;
  localparam int PARSE_DELAY_US = 100;
  // Longest time, so rounded down
  localparam int PARSE_CYCLES   = (PARSE_DELAY_US * CLK_KHZ) / 1000;
  localparam logic [11:0] PARSE_LAST = 12'(PARSE_CYCLES - 1);

  // ==========================================================
  // Types
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } swbt_byte_type;

  typedef enum logic [5:0] {
    ST_SLEEP = 6'h01,
    ST_IDLE  = 6'h02,
    ST_RECV  = 6'h04,
    ST_PARSE = 6'h08,
    ST_EXEC  = 6'h10,
    ST_SEND  = 6'h20
  } swbt_state_type;

  typedef enum logic [1:0] {
    RS_WAKE = 2'h0,
    RS_OUT  = 2'h1,
    RS_EXEC = 2'h2,
    RS_COMM = 2'h3
  } swbt_reply_type;

  // ==========================================================
  // One byte into the CRC, bit 0 first as it travels the wire
  function automatic logic [15:0] swbt_crc_byte(logic [15:0] crc,
                                                logic [7:0]  d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (d[i] ^ c[15]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

endpackage

// file: hdl/swbt_framer.sv
// Block framer, reply generator and two-entry transmit buffer
`timescale 1ns/1ps
module swbt_framer
  import swbt_pkg::*;
#(
  parameter int FIFO_DEPTH = 2,
  parameter int MEM_BYTES  = 39
) (
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic          wakeEvt,
  input  wire swbt_byte_type rxByte,
  output swbt_byte_type      txByte,
  input  wire logic          txReady,
  output logic               lowPower,
  output logic               cmdStart,
  output logic [7:0]         cmdLen,
  input  wire logic [5:0]    cmdRdAddr,
  output logic [7:0]         cmdRdData,
  input  wire logic          engParseDone,
  input  wire logic          engParseOk,
  input  wire logic          engDone,
  input  wire logic          engOk,
  input  wire logic          resWrEn,
  input  wire logic [5:0]    resWrAddr,
  input  wire logic [7:0]    resWrData,
  input  wire logic [5:0]    resLen
);

  localparam int PW = $clog2(FIFO_DEPTH);

  // ==========================================================
  // Control state
  swbt_state_type state_r, state_nxt;
  swbt_reply_type reply_r, reply_nxt;
  logic [7:0]  rxCnt_r, rxCnt_nxt;
  logic [5:0]  rxIdx_r, rxIdx_nxt;
  logic [15:0] rxCrc_r, rxCrc_nxt;
  logic        crcLoOk_r, crcLoOk_nxt;
  logic        commErr_r, commErr_nxt;
  logic        reject_r, reject_nxt;
  logic [11:0] parseCnt_r, parseCnt_nxt;
  logic [5:0]  outLen_r, outLen_nxt;
  logic [5:0]  txIdx_r, txIdx_nxt;
  logic [15:0] txCrc_r, txCrc_nxt;
  logic        cmdStart_r, cmdStart_nxt;
  logic [7:0]  rxMem [MEM_BYTES];
  logic [7:0]  resMem [MEM_BYTES];
  logic [7:0]  cmdRdData_r;
  logic        rxWr;
  logic        sleepNow;
  logic        transmitNow;
  logic [5:0]  payLen;
  logic [7:0]  pushData;
  logic        push;
  logic        inReady;

  assign sleepNow    = rxByte.valid && state_r == ST_IDLE
                       && rxByte.data == FLAG_SLEEP;
  assign transmitNow = rxByte.valid && state_r == ST_IDLE
                       && rxByte.data == FLAG_TRANSMIT;
  assign rxWr        = rxByte.valid && state_r == ST_RECV;
  assign payLen      = (reply_r == RS_OUT) ? outLen_r : 6'h01;

  // Bytes leave as count, payload, CRC low, CRC high
  always_comb begin
    if (txIdx_r == 6'h00) begin
      pushData = 8'(payLen) + BLOCK_EXTRA;
    end else if (txIdx_r <= payLen) begin
      case (reply_r)
        RS_WAKE: pushData = CODE_WAKE;
        RS_OUT:  pushData = resMem[txIdx_r - 6'h01];
        RS_EXEC: pushData = CODE_EXEC_ERR;
        RS_COMM: pushData = CODE_COMM_ERR;
        default: pushData = CODE_COMM_ERR;
      endcase
    end else if (txIdx_r == payLen + 6'h01) begin
      pushData = txCrc_r[7:0];
    end else begin
      pushData = txCrc_r[15:8];
    end
  end
  assign push = state_r == ST_SEND && inReady;

  always_comb begin
    state_nxt    = state_r;
    reply_nxt    = reply_r;
    rxCnt_nxt    = rxCnt_r;
    rxIdx_nxt    = rxIdx_r;
    rxCrc_nxt    = rxCrc_r;
    crcLoOk_nxt  = crcLoOk_r;
    commErr_nxt  = commErr_r;
    reject_nxt   = reject_r;
    parseCnt_nxt = parseCnt_r;
    outLen_nxt   = outLen_r;
    txIdx_nxt    = txIdx_r;
    txCrc_nxt    = txCrc_r;
    cmdStart_nxt = 1'b0;
    case (state_r)
      ST_SLEEP: begin
        if (wakeEvt) begin
          state_nxt = ST_IDLE;
          reply_nxt = RS_WAKE;
        end
      end
      ST_IDLE: begin
        // Unknown flag values fall through untouched
        if (sleepNow) begin
          state_nxt = ST_SLEEP;
        end else if (transmitNow) begin
          state_nxt = ST_SEND;
          txIdx_nxt = 6'h00;
          txCrc_nxt = CRC_INIT;
        end else if (rxByte.valid && rxByte.data == FLAG_COMMAND) begin
          state_nxt = ST_RECV;
          rxIdx_nxt = 6'h00;
          rxCrc_nxt = CRC_INIT;
        end
      end
      ST_RECV: begin
        if (rxByte.valid) begin
          rxIdx_nxt = rxIdx_r + 6'h01;
          if (rxIdx_r == 6'h00) begin
            rxCnt_nxt = rxByte.data;
            rxCrc_nxt = swbt_crc_byte(rxCrc_r, rxByte.data);
            // Length unknown, so a bad count ends the block at once
            if (rxByte.data < BLOCK_MIN || rxByte.data > BLOCK_MAX) begin
              commErr_nxt  = 1'b1;
              state_nxt    = ST_PARSE;
              parseCnt_nxt = 12'h000;
            end
          end else if (8'(rxIdx_r) < rxCnt_r - 8'h02) begin
            rxCrc_nxt = swbt_crc_byte(rxCrc_r, rxByte.data);
          end else if (8'(rxIdx_r) == rxCnt_r - 8'h02) begin
            crcLoOk_nxt = rxByte.data == rxCrc_r[7:0];
          end else begin
            commErr_nxt  = !(crcLoOk_r
                             && rxByte.data == rxCrc_r[15:8]);
            cmdStart_nxt = crcLoOk_r && rxByte.data == rxCrc_r[15:8];
            state_nxt    = ST_PARSE;
            parseCnt_nxt = 12'h000;
          end
        end
      end
      ST_PARSE: begin
        // Flags are not looked at here, so Transmit goes unanswered
        if (engParseDone && !engParseOk) begin
          reject_nxt = 1'b1;
        end
        parseCnt_nxt = parseCnt_r + 12'h001;
        if (parseCnt_r == PARSE_LAST) begin
          if (commErr_r) begin
            state_nxt = ST_IDLE;
            reply_nxt = RS_COMM;
          end else if (reject_r || (engParseDone && !engParseOk)) begin
            state_nxt = ST_IDLE;
            reply_nxt = RS_EXEC;
          end else begin
            state_nxt = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (engDone) begin
          state_nxt  = ST_IDLE;
          reply_nxt  = engOk ? RS_OUT : RS_EXEC;
          outLen_nxt = (resLen == 6'h00) ? 6'h01 : resLen;
        end
      end
      ST_SEND: begin
        if (push) begin
          txIdx_nxt = txIdx_r + 6'h01;
          if (txIdx_r <= payLen) begin
            txCrc_nxt = swbt_crc_byte(txCrc_r, pushData);
          end
          if (txIdx_r == payLen + 6'h02) begin
            state_nxt = ST_IDLE;            // reply kept for rereads
          end
        end
      end
      default: state_nxt = ST_SLEEP;
    endcase
    if (state_nxt == ST_SLEEP) begin
      commErr_nxt = 1'b0;
      reject_nxt  = 1'b0;
      outLen_nxt  = 6'h01;
    end
    if (state_r == ST_IDLE && state_nxt == ST_RECV) begin
      commErr_nxt = 1'b0;
      reject_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r    <= ST_SLEEP;
      reply_r    <= RS_WAKE;
      rxCnt_r    <= 8'h00;
      rxIdx_r    <= 6'h00;
      rxCrc_r    <= CRC_INIT;
      crcLoOk_r  <= 1'b0;
      commErr_r  <= 1'b0;
      reject_r   <= 1'b0;
      parseCnt_r <= 12'h000;
      outLen_r   <= 6'h01;
      txIdx_r    <= 6'h00;
      txCrc_r    <= CRC_INIT;
      cmdStart_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      reply_r    <= reply_nxt;
      rxCnt_r    <= rxCnt_nxt;
      rxIdx_r    <= rxIdx_nxt;
      rxCrc_r    <= rxCrc_nxt;
      crcLoOk_r  <= crcLoOk_nxt;
      commErr_r  <= commErr_nxt;
      reject_r   <= reject_nxt;
      parseCnt_r <= parseCnt_nxt;
      outLen_r   <= outLen_nxt;
      txIdx_r    <= txIdx_nxt;
      txCrc_r    <= txCrc_nxt;
      cmdStart_r <= cmdStart_nxt;
    end
  end

  // ==========================================================
  // Block stores; no reset so they map onto plain RAM
  always_ff @(posedge clk_sys) begin
    if (rxWr && int'(rxIdx_r) < MEM_BYTES) begin
      rxMem[rxIdx_r] <= rxByte.data;
    end
    if (resWrEn && int'(resWrAddr) < MEM_BYTES) begin
      resMem[resWrAddr] <= resWrData;
    end
    cmdRdData_r <= rxMem[cmdRdAddr + 6'h01];
  end

  assign cmdStart  = cmdStart_r;
  assign cmdLen    = rxCnt_r - BLOCK_EXTRA;
  assign cmdRdData = cmdRdData_r;
  assign lowPower  = state_r == ST_SLEEP;

  // ==========================================================
  // Transmit buffer: a stalled receiver holds the generator
  logic [7:0]  fifoMem [FIFO_DEPTH];
  logic [PW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [PW:0] fill_r, fill_nxt;
  logic        pop;

  // Fill count is one bit wider than a pointer, so full is FIFO_DEPTH
  assign inReady = fill_r != (PW+1)'(FIFO_DEPTH);
  assign pop     = txByte.valid && txReady;
  assign txByte  = '{valid: fill_r != '0, data: fifoMem[rdPtr_r]};

  always_comb begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    fill_nxt  = fill_r;
    if (push) begin
      wrPtr_nxt = (int'(wrPtr_r) == FIFO_DEPTH - 1) ? '0 : wrPtr_r + 1'b1;
    end
    if (pop) begin
      rdPtr_nxt = (int'(rdPtr_r) == FIFO_DEPTH - 1) ? '0 : rdPtr_r + 1'b1;
    end
    fill_nxt = fill_r + (PW+1)'(push) - (PW+1)'(pop);
    if (state_r == ST_SLEEP) begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
      fill_nxt  = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      fill_r  <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      fill_r  <= fill_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      fifoMem[wrPtr_r] <= pushData;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_wake_code: assert property (
    push && txIdx_r == 6'h01 && reply_r == RS_WAKE |-> pushData == 8'h11)
    else $error("wake status byte wrong");
  chk_out_reread: assert property (
    state_r == ST_SEND && reply_r == RS_OUT ##1 state_r == ST_IDLE
    |-> reply_r == RS_OUT)
    else $error("output lost after send");
  chk_exec_error: assert property (
    push && txIdx_r == 6'h01 && reply_r == RS_EXEC |-> pushData == 8'h0F)
    else $error("execution error byte wrong");
  chk_comm_error: assert property (
    state_r == ST_PARSE && commErr_r |=> state_r != ST_EXEC)
    else $error("bad block reached execution");
  chk_code_length: assert property (
    push && txIdx_r == 6'h00 && reply_r != RS_OUT |-> pushData == 8'h04)
    else $error("code block not four bytes");
  chk_parse_hold: assert property (
    state_r == ST_PARSE && parseCnt_r != PARSE_LAST |=> state_r == ST_PARSE)
    else $error("parse left early");
  chk_busy_ignore: assert property (
    state_r == ST_EXEC && !engDone |=> state_r == ST_EXEC)
    else $error("execution abandoned");
  chk_sleep_flush: assert property (
    sleepNow |=> state_r == ST_SLEEP ##1 fill_r == '0 && lowPower)
    else $error("sleep did not clear engine");
  chk_crc_last: assert property (
    push && txIdx_r == payLen + 6'h02 |-> pushData == txCrc_r[15:8]
    ##1 state_r == ST_IDLE)
    else $error("last byte not CRC high");
  chk_count_range: assert property (
    rxWr && rxIdx_r == 6'h00 && rxByte.data > 8'h27
    |=> state_r == ST_PARSE && commErr_r)
    else $error("oversize count accepted");

  cov_wake_reply: cover property (push && reply_r == RS_WAKE);
  cov_exec_ok:    cover property (state_r == ST_EXEC && engDone && engOk);
  cov_comm_err:   cover property (push && reply_r == RS_COMM);
  cov_sleep:      cover property (sleepNow);

endmodule

// file: tb/swbt_host_model.sv
// System controller model: drives wake, flags and blocks, sinks replies
`timescale 1ns/1ps
module swbt_host_model
  import swbt_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          stallReq,
  input  wire swbt_byte_type txByte,
  output logic               wakeEvt,
  output swbt_byte_type      rxByte,
  output logic               txReady
);
  // ==========================================================
  // Link drive
  initial begin
    wakeEvt = 1'b0;
    rxByte  = '{valid: 1'b0, data: 8'hA5};
  end

  // Reply sink stalls whenever the bench asks, to fill the buffer
  assign txReady = !stallReq;

  task automatic wake();
    @(posedge clk_sys);
    wakeEvt <= 1'b1;
    @(posedge clk_sys);
    wakeEvt <= 1'b0;
  endtask

  // Between bytes the line shows the inverse, never a stale byte
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk_sys);
    rxByte <= '{valid: 1'b1, data: b};
    @(posedge clk_sys);
    rxByte <= '{valid: 1'b0, data: ~b};
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the block transaction framer
`timescale 1ns/1ps
module tb_top
  import swbt_pkg::*;
;
  // ==========================================================
  // Signals
  logic          clk_sys = 1'b0;
  logic          reset = 1'b1;
  logic          stallReq = 1'b0;
  logic          wakeEvt, txReady, lowPower, cmdStart;
  swbt_byte_type rxByte, txByte;
  logic [7:0]    cmdLen, cmdRdData, resWrData = 8'h00;
  logic [5:0]    cmdRdAddr = 6'h00, resWrAddr = 6'h00, resLen = 6'h01;
  logic          engParseDone = 1'b0, engParseOk = 1'b0;
  logic          engDone = 1'b0, engOk = 1'b0, resWrEn = 1'b0;
  logic [7:0]    expQ[$], blk[$], pkt[$], expV, op, r;
  logic [7:0]    badCnt[2] = '{8'h03, 8'h28};
  logic [31:0]   rndState = 32'hA890;
  int            errorCnt = 0;
  int            nChecks = 0;

  always #25 clk_sys = ~clk_sys;

  swbt_framer i_dut (
    .clk_sys(clk_sys), .reset(reset), .wakeEvt(wakeEvt),
    .rxByte(rxByte), .txByte(txByte), .txReady(txReady),
    .lowPower(lowPower), .cmdStart(cmdStart), .cmdLen(cmdLen),
    .cmdRdAddr(cmdRdAddr), .cmdRdData(cmdRdData),
    .engParseDone(engParseDone), .engParseOk(engParseOk),
    .engDone(engDone), .engOk(engOk), .resWrEn(resWrEn),
    .resWrAddr(resWrAddr), .resWrData(resWrData), .resLen(resLen));

  swbt_host_model i_host (
    .clk_sys(clk_sys), .stallReq(stallReq), .txByte(txByte),
    .wakeEvt(wakeEvt), .rxByte(rxByte), .txReady(txReady));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    rndState = rndState ^ (rndState << 13);
    rndState = rndState ^ (rndState >> 17);
    rndState = rndState ^ (rndState << 5);
    return rndState;
  endfunction

  // Bit 0 of each byte enters first, as on the wire
  function automatic logic [15:0] crcOf(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (q[k]) begin
      for (int i = 0; i < 8; i++) begin
        c = {c[14:0], 1'b0} ^ ((q[k][i] ^ c[15]) ? 16'h8005 : 16'h0000);
      end
    end
    return c;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic build(input logic [7:0] p[$]);
    logic [15:0] c;
    blk = {8'(p.size() + 3)};
    foreach (p[k]) blk.push_back(p[k]);
    c = crcOf(blk);
    blk.push_back(c[7:0]);
    blk.push_back(c[15:8]);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    check(8'(expQ.size()), 8'h00);
    repeat (20) @(posedge clk_sys);
  endtask

  task automatic poll(input logic [7:0] p[$]);
    build(p);
    foreach (blk[k]) expQ.push_back(blk[k]);
    i_host.send_byte(FLAG_TRANSMIT);
    drain();
  endtask

  task automatic command(input logic [7:0] p[$], input logic badCrc);
    build(p);
    if (badCrc) begin
      blk[blk.size() - 1] ^= 8'h01;
    end
    i_host.send_byte(FLAG_COMMAND);
    foreach (blk[k]) i_host.send_byte(blk[k]);
  endtask

  task automatic finishTest();
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Reply monitor: every accepted byte must match the oldest note
  always @(posedge clk_sys) begin
    stallReq <= xs() < 32'h6000_0000;
    if (txByte.valid === 1'b1 && txReady === 1'b1) begin
      expV = expQ.size() > 0 ? expQ.pop_front() : ~txByte.data;
      check(txByte.data, expV);
    end
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    errorCnt++;
    finishTest();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge clk_sys);
    check(8'(lowPower), 8'h01);
    reset <= 1'b0;
    i_host.wake();
    i_host.send_byte(8'h55);
    poll('{CODE_WAKE});
    // Corrupt CRC; a poll inside the parse delay must stay silent
    op = 8'(xs());
    command('{op, 8'h00, 8'h00, 8'h00}, 1'b1);
    repeat (200) @(posedge clk_sys);
    i_host.send_byte(FLAG_TRANSMIT);
    repeat (1900) @(posedge clk_sys);
    poll('{CODE_COMM_ERR});
    foreach (badCnt[k]) begin
      i_host.send_byte(FLAG_COMMAND);
      i_host.send_byte(badCnt[k]);
      repeat (2010) @(posedge clk_sys);
      poll('{CODE_COMM_ERR});
    end
    // Four-byte and largest packets: rejected, then executed
    for (int v = 0; v < 2; v++) begin
      op = 8'(xs());
      pkt = {op};
      repeat (v ? 35 : 3) pkt.push_back(8'(xs()));
      command(pkt, 1'b0);
      for (int n = 0; n < 100 && cmdStart !== 1'b1; n++) begin
        @(negedge clk_sys);
      end
      check(8'(cmdStart), 8'h01);
      check(cmdRdData, op);
      check(cmdLen, 8'(pkt.size()));
      @(posedge clk_sys);
      cmdRdAddr <= 6'(pkt.size() - 1);
      repeat (2) @(negedge clk_sys);
      check(cmdRdData, pkt[pkt.size() - 1]);
      @(posedge clk_sys);
      cmdRdAddr <= 6'h00;
      engParseDone <= 1'b1;
      engParseOk <= v[0];
      @(posedge clk_sys);
      engParseDone <= 1'b0;
      repeat (2010) @(posedge clk_sys);
      if (v == 0) begin
        poll('{CODE_EXEC_ERR});
      end else begin
        i_host.send_byte(FLAG_TRANSMIT);
        repeat (30) @(posedge clk_sys);
        r = 8'(xs());
        for (int a = 0; a < 2; a++) begin
          @(posedge clk_sys);
          resWrEn <= 1'b1;
          resWrAddr <= 6'(a);
          resWrData <= a ? r : 8'h00;
        end
        @(posedge clk_sys);
        resWrEn <= 1'b0;
        resLen <= 6'h02;
        engDone <= 1'b1;
        engOk <= 1'b1;
        @(posedge clk_sys);
        engDone <= 1'b0;
        poll('{8'h00, r});
        poll('{8'h00, r});
      end
    end
    // Sleep drops the result; only a new wake answers again
    i_host.send_byte(FLAG_SLEEP);
    repeat (3) @(negedge clk_sys);
    check(8'(lowPower), 8'h01);
    i_host.send_byte(FLAG_TRANSMIT);
    repeat (20) @(posedge clk_sys);
    i_host.wake();
    poll('{CODE_WAKE});
    // Short command: one wait of parse plus execution, no middle poll
    pkt = {8'(xs()), 8'h00, 8'h00, 8'h00};
    command(pkt, 1'b0);
    repeat (2010) @(posedge clk_sys);
    engDone <= 1'b1;
    engOk <= 1'b0;
    @(posedge clk_sys);
    engDone <= 1'b0;
    repeat (5) @(posedge clk_sys);
    poll('{CODE_EXEC_ERR});
    i_host.send_byte(FLAG_SLEEP);
    repeat (5) @(posedge clk_sys);
    finishTest();
  end
endmodule
